//--- rtl/sysbus_request_flow_ctrl.sv
/*
  Request issue and flow control of the processor system interface, with its
  control and status registers on APB. Assumes a transaction queue on the same
  clock that holds its head until taken, response logic on the same clock that
  flags the end of read responses and of other external requests, and agent
  pins that arrive asynchronously and are synchronised here.
*/
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctrl_map.svh"

// How it works
// - Reads issue only if read-ready was low two cycles before the address cycle.
// - Writes issue only if write-ready was low two cycles before; agent must signal early.
// - Legacy mode: write-ready negated after a fill holds writes off four cycles.
// - Legacy timing and 32-bit bus mode outside split reads: at least two idle cycles follow every write address/data pair.
// - Legacy mode: reads after writes keep one address per four cycles.
// - In 32-bit bus mode the legacy, reissue and pipelined selections do nothing.
// - Write reissue: write-ready also needed in the address cycle, else reissue.
// - Pipelined writes: sample only two cycles before; agent takes one extra write.
// - Split reads: read-ready needed before and during the address cycle, else reissue.
// - Split reads: addresses may follow every three cycles without releasing.
// - Split reads: release when the queue is empty and reads are outstanding.
// - Split reads: release when blocked by readiness and reads or requests wait.
// - Split reads: release on external request at a transaction set boundary.
// - Split reads: release when a write set ends with reads still outstanding.
// - At most four reads outstanding; release before any further read.
// - Split reads use reissue timing for writes, never pipelined timing.
// - Release may coincide with read-ready negation; only the first read counts.
// - After an uncompelled release, signal pending work while the queue waits.
// - Bus release is a low pulse of exactly one cycle.
module sysbus_request_flow_ctrl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Transaction queue head
  input  wire logic        txq_valid,
  input  wire logic        txq_read,
  input  wire logic        txq_set_last,
  output logic             txq_take,
  // Response logic
  input  wire logic        resp_last,
  input  wire logic        ext_done,
  // Agent pins
  input  wire logic        agent_read_accept_n,
  input  wire logic        agent_write_accept_n,
  input  wire logic        agent_bus_request_n,
  input  wire logic        agent_drive_valid_n,
  input  wire logic        null_return_command,
  // Processor pins
  output logic             cpu_drive_valid_n,
  output logic             cpu_addr_cycle,
  output logic             cpu_addr_is_read,
  output logic             cpu_data_cycle,
  output logic             bus_release_n,
  output logic             cpu_more_pending_n,
  output logic             bus_master
);

  flow_ctrl_pkg::state_t q;
  flow_ctrl_pkg::state_t d;

  // Decision terms, all recomputed every cycle from the state record, the queue head, the response inputs and the APB inputs.
  logic rd_ok;
  logic wr_ok;
  logic ext;
  logic msr;
  logic reissue;
  logic wide;
  logic head_ok;
  logic at_limit;
  logic checked;
  logic cf_busy;
  logic can_act;
  logic rel_msr;
  logic release_now;
  logic issue;
  logic take_chk;
  logic taken_rd;
  logic taken_wr;
  logic taken_last;
  logic null_seen;
  logic slave_exit;
  logic apb_wr;
  logic apb_setup;
  logic mapped;

  // ========================================================================
  // Decisions
  always_comb begin
    // Synchronised pins, stored active high.
    rd_ok = q.rr2;
    wr_ok = q.wr2;
    ext   = q.er2;
    msr     = (q.mode == flow_ctrl_pkg::MODE_MSR);
    reissue = !q.legacy32 && (q.mode == flow_ctrl_pkg::MODE_REISSUE);
    // Four-cycle spacing in legacy timing and in the 32-bit bus mode, except in split-read timing.
    wide = !msr && (q.legacy32 || (q.mode == flow_ctrl_pkg::MODE_LEGACY));
    // The second sync stage shows the pin as it was two cycles ago.
    head_ok  = txq_read ? rd_ok : wr_ok;
    at_limit = txq_read && (q.outst == `FC_OUTST_MAX);
    // Pipelined writes skip the address-cycle check; split reads never do.
    checked  = msr || (reissue && !txq_read);
    cf_busy  = q.cf1_v || q.cf2_v;
    can_act  = (q.st == flow_ctrl_pkg::ST_IDLE) && (q.gap == 2'h0) && !cf_busy;
    // Release conditions of split-read timing; any one of them hands the bus over.
    rel_msr  = msr && (
      (!txq_valid && (q.outst != 3'h0)) ||
      (txq_valid && !head_ok && ((q.outst != 3'h0) || ext)) ||
      (ext && !q.set_open) ||
      (q.set_done && (q.outst != 3'h0)) ||
      (txq_valid && at_limit));
    release_now = can_act && (rel_msr || (!msr && ext && !q.set_open));
    // Release beats issue, so a waiting external request is not starved by a long queue.
    issue = can_act && !release_now && txq_valid && head_ok && !at_limit;
    // In the confirm cycle the second stage shows the pin of the address cycle.
    take_chk   = q.cf2_v && (q.cf2_rd ? rd_ok : wr_ok);
    taken_rd   = (issue && !checked && txq_read) || (take_chk && q.cf2_rd);
    taken_wr   = (issue && !checked && !txq_read) || (take_chk && !q.cf2_rd);
    taken_last = (issue && !checked && !txq_read && txq_set_last) ||
                 (take_chk && !q.cf2_rd && q.cf2_last);
    null_seen  = q.vi2 && q.nl2;
    // Responses come back in issue order, so a count is enough to track them.
    slave_exit = null_seen || ext_done || (resp_last && (q.outst == 3'h1));
    apb_wr     = psel && penable && pwrite;
    apb_setup  = psel && !penable;
    mapped     = (paddr == `FC_OFS_CTRL) || (paddr == `FC_OFS_STATUS);
  end

  // ========================================================================
  // Next state
  always_comb begin
    d = q;
    d.rr1 = !agent_read_accept_n;
    d.rr2 = q.rr1;
    d.wr1 = !agent_write_accept_n;
    d.wr2 = q.wr1;
    d.er1 = !agent_bus_request_n;
    d.er2 = q.er1;
    d.vi1 = !agent_drive_valid_n;
    d.vi2 = q.vi1;
    d.nl1 = null_return_command;
    d.nl2 = q.nl1;
    // The next address may come gap plus one cycles later, and never in a write data cycle.
    if (q.gap != 2'h0) begin
      d.gap = q.gap - 2'h1;
    end
    // The head stays queued until its confirm stage; an abort simply lets it issue again.
    d.cf1_v    = issue && checked;
    d.cf1_rd   = txq_read;
    d.cf1_last = txq_set_last;
    d.cf2_v    = q.cf1_v;
    d.cf2_rd   = q.cf1_rd;
    d.cf2_last = q.cf1_last;
    // A completion and a response in the same cycle cancel out.
    if (taken_rd && !(resp_last && (q.outst != 3'h0))) begin
      d.outst = q.outst + 3'h1;
    end else if (!taken_rd && resp_last && (q.outst != 3'h0)) begin
      d.outst = q.outst - 3'h1;
    end
    if (can_act) begin
      d.set_done = 1'b0;
    end
    if (taken_wr) begin
      d.set_open = !taken_last;
      d.set_done = taken_last;
    end
    unique case (q.st)
      flow_ctrl_pkg::ST_IDLE: begin
        if (release_now) begin
          d.st     = flow_ctrl_pkg::ST_REL;
          d.uncomp = (q.outst != 3'h0);
        end else if (issue && !txq_read) begin
          d.st  = flow_ctrl_pkg::ST_DATA;
          d.gap = wide ? `FC_GAP_WIDE_WR : `FC_GAP_FAST_WR;
        end else if (issue) begin
          d.gap = wide ? `FC_GAP_WIDE_RD : `FC_GAP_FAST_RD;
          if (!msr) begin
            // Outside split reads every read hands the bus over at once.
            d.st     = flow_ctrl_pkg::ST_REL;
            d.uncomp = 1'b1;
          end
        end
      end
      flow_ctrl_pkg::ST_DATA: begin
        d.st = flow_ctrl_pkg::ST_IDLE;
      end
      flow_ctrl_pkg::ST_REL: begin
        d.st = flow_ctrl_pkg::ST_SLAVE;
      end
      flow_ctrl_pkg::ST_SLAVE: begin
        if (slave_exit) begin
          d.st     = flow_ctrl_pkg::ST_IDLE;
          d.uncomp = 1'b0;
        end
      end
    endcase
    d.more_pend = (q.st == flow_ctrl_pkg::ST_SLAVE) && q.uncomp && txq_valid
                  && !slave_exit;
    // Mode is meant to change only while the interface is quiet.
    if (apb_wr && (paddr == `FC_OFS_CTRL)) begin
      d.mode     = flow_ctrl_pkg::timing_mode_t'(pwdata[`FC_CTRL_MODE]);
      d.legacy32 = pwdata[`FC_CTRL_L32];
    end
    if (apb_setup) begin
      d.prdata = 32'h0000_0000;
      if (paddr == `FC_OFS_CTRL) begin
        d.prdata[`FC_CTRL_MODE] = q.mode;
        d.prdata[`FC_CTRL_L32]  = q.legacy32;
      end else if (paddr == `FC_OFS_STATUS) begin
        d.prdata[`FC_ST_OUTST]  = q.outst;
        d.prdata[`FC_ST_SLAVE]  = (q.st == flow_ctrl_pkg::ST_SLAVE);
        d.prdata[`FC_ST_CFBUSY] = cf_busy;
      end
    end
  end

  // ========================================================================
  // State register
  // Reset returns every field to zero: legacy timing, no reads out, master state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= flow_ctrl_pkg::state_t'(0);
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs
  // Address strobes are combinational so that an issue decision reaches the pins in the
  // same cycle; the write data cycle and the release strobe come from the state register.
  assign pready             = 1'b1;
  assign prdata             = q.prdata;
  assign pslverr            = psel && penable && !mapped;
  assign txq_take           = (issue && !checked) || take_chk;
  assign cpu_addr_cycle     = issue;
  assign cpu_addr_is_read   = issue && txq_read;
  assign cpu_data_cycle     = (q.st == flow_ctrl_pkg::ST_DATA);
  assign cpu_drive_valid_n  = !(issue || (q.st == flow_ctrl_pkg::ST_DATA));
  assign bus_release_n      = (q.st != flow_ctrl_pkg::ST_REL);
  assign cpu_more_pending_n = !q.more_pend;
  assign bus_master         = (q.st == flow_ctrl_pkg::ST_IDLE) || (q.st == flow_ctrl_pkg::ST_DATA);

  // ========================================================================
  // Assertions
  // The properties watch the decisions as well as the pins, so that a broken gate shows
  // at the cycle where it goes wrong rather than as a hang further down the bench.
  sequence s_wr_abort;
    issue && !txq_read && checked && agent_write_accept_n;
  endsequence

  sequence s_rd_abort;
    issue && txq_read && msr && agent_read_accept_n;
  endsequence

  // Hand-over: one low cycle of the release strobe, then slave state.
  sequence s_hand_over;
    !bus_release_n ##1 (bus_release_n && !bus_master);
  endsequence

  chk_read_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && txq_read) |-> !$past(agent_read_accept_n, 2))
    else $error("read issued without read-ready two cycles earlier");

  chk_write_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && !txq_read) |-> !$past(agent_write_accept_n, 2))
    else $error("write issued without write-ready two cycles earlier");

  chk_legacy_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && wide) |=> !issue [*3])
    else $error("legacy spacing of four cycles broken");

  chk_l32_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && !txq_read && q.legacy32 && !msr) |-> ##1 cpu_data_cycle ##1 !issue [*2])
    else $error("32-bit bus mode did not fall back to legacy write timing");

  chk_write_reissue: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_abort |-> ##2 !txq_take)
    else $error("aborted write was taken from the queue");

  chk_read_reissue: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_abort |-> ##1 !txq_take ##1 !txq_take)
    else $error("aborted split read was taken from the queue");

  chk_empty_release: assert property (@(posedge pclk) disable iff (!presetn)
    (can_act && msr && !txq_valid && (q.outst != 3'h0)) |=> !bus_release_n)
    else $error("empty queue with reads out did not release the bus");

  chk_read_limit: assert property (@(posedge pclk) disable iff (!presetn)
    (q.outst == `FC_OUTST_MAX) |-> !(issue && txq_read))
    else $error("fifth outstanding read issued");

  chk_release_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(bus_release_n) |=> bus_release_n ##0 (q.st == flow_ctrl_pkg::ST_SLAVE))
    else $error("release pulse not exactly one cycle");

  chk_pending_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ((q.st == flow_ctrl_pkg::ST_SLAVE) && q.uncomp && txq_valid && !slave_exit)
      |=> !cpu_more_pending_n)
    else $error("pending indication missing after uncompelled release");

  chk_unchecked_take: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && !checked) |-> txq_take)
    else $error("unchecked transfer not taken in its address cycle");

  chk_split_confirm: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && msr) |-> !txq_take)
    else $error("split-mode transfer taken before its confirm stage");

  chk_l32_unchecked: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && q.legacy32 && !msr) |-> txq_take)
    else $error("32-bit bus mode used an address-cycle check");

  chk_split_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && msr) |=> !issue ##1 !issue)
    else $error("split-mode address during its confirm stage");

  chk_write_data: assert property (@(posedge pclk) disable iff (!presetn)
    (issue && !txq_read) |=> (cpu_data_cycle && !cpu_drive_valid_n))
    else $error("write address not followed by its data cycle");

  chk_pair_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_data_cycle && wide) |=> !issue ##1 !issue)
    else $error("fewer than two idle cycles after a write pair");

  chk_read_stall: assert property (@(posedge pclk) disable iff (!presetn)
    (can_act && txq_valid && txq_read && !rd_ok) |-> !issue)
    else $error("read issued while read-ready was negated");

  chk_write_stall: assert property (@(posedge pclk) disable iff (!presetn)
    (can_act && txq_valid && !txq_read && !wr_ok) |-> !issue)
    else $error("write issued while write-ready was negated");

  chk_ext_release: assert property (@(posedge pclk) disable iff (!presetn)
    (can_act && ext && !q.set_open) |=> s_hand_over)
    else $error("external request at a set boundary did not release the bus");

  chk_blocked_release: assert property (@(posedge pclk) disable iff (!presetn)
    (can_act && msr && txq_valid && !head_ok && (ext || (q.outst != 3'h0))) |=> s_hand_over)
    else $error("blocked head with work waiting did not release the bus");

  chk_set_release: assert property (@(posedge pclk) disable iff (!presetn)
    (can_act && msr && q.set_done && (q.outst != 3'h0)) |=> s_hand_over)
    else $error("finished write set with reads out did not release the bus");

  chk_limit_release: assert property (@(posedge pclk) disable iff (!presetn)
    (can_act && msr && txq_valid && at_limit) |=> s_hand_over)
    else $error("read head at the limit did not release the bus");

  chk_pending_idle: assert property (@(posedge pclk) disable iff (!presetn)
    bus_master |-> cpu_more_pending_n)
    else $error("pending indication shown while master");

  chk_null_return: assert property (@(posedge pclk) disable iff (!presetn)
    ((q.st == flow_ctrl_pkg::ST_SLAVE) && null_seen) |=> bus_master)
    else $error("null request did not return the bus");

endmodule // sysbus_request_flow_ctrl

`default_nettype wire

//--- rtl/flow_ctrl_map.svh
/*
  Register offsets, field positions, reset values and spacing counts for the
  request issue and flow-control block. Assumes a 32-bit APB with byte addresses.
*/
`ifndef FLOW_CTRL_MAP_SVH
`define FLOW_CTRL_MAP_SVH

// ==========================================================================
// Register offsets
`define FC_OFS_CTRL      8'h00
`define FC_OFS_STATUS    8'h04

// ==========================================================================
// Field positions
`define FC_CTRL_MODE     1:0
`define FC_CTRL_L32      2
`define FC_ST_OUTST      2:0
`define FC_ST_SLAVE      3
`define FC_ST_CFBUSY     4

// ==========================================================================
// Reset values
`define FC_CTRL_RST      32'h0000_0000

// ==========================================================================
// Timing counts in system cycles
`define FC_SAMPLE_LAG    2
`define FC_OUTST_MAX     3'h4
`define FC_GAP_WIDE_WR   2'h3
`define FC_GAP_WIDE_RD   2'h3
`define FC_GAP_FAST_WR   2'h0
`define FC_GAP_FAST_RD   2'h1

`endif

//--- rtl/flow_ctrl_pkg.sv
/*
  Types of the request issue and flow-control block: bus states, timing
  modes and the packed state record. Assumes the map header for numbers.
*/
package flow_ctrl_pkg;

  // ========================================================================
  // Bus ownership states
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_REL, ST_SLAVE} bus_state_t;

  // ========================================================================
  // Timing modes
  typedef enum logic [1:0] {MODE_LEGACY, MODE_REISSUE, MODE_PIPE, MODE_MSR} timing_mode_t;

  // ========================================================================
  // Whole state of the block
  typedef struct packed {
    bus_state_t   st;
    logic [1:0]   gap;
    logic [2:0]   outst;
    logic         cf1_v;
    logic         cf1_rd;
    logic         cf1_last;
    logic         cf2_v;
    logic         cf2_rd;
    logic         cf2_last;
    logic         set_open;
    logic         set_done;
    logic         uncomp;
    logic         more_pend;
    timing_mode_t mode;
    logic         legacy32;
    logic [31:0]  prdata;
    logic         rr1;
    logic         rr2;
    logic         wr1;
    logic         wr2;
    logic         er1;
    logic         er2;
    logic         vi1;
    logic         vi2;
    logic         nl1;
    logic         nl2;
  } state_t;

endpackage

//--- test/agent_model.sv
/* Model of the external agent: readiness pins, read responses in issue order,
   null and other external requests. Assumes the device pins on pclk. */
`timescale 1ns/1ps
`default_nettype none
module agent_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench controls
  input  wire logic rd_hold,
  input  wire logic wr_hold,
  input  wire logic ext_want,
  input  wire logic split_mode,
  input  wire logic slow,
  // Device side
  input  wire logic cpu_addr_cycle,
  input  wire logic cpu_addr_is_read,
  input  wire logic bus_master,
  output logic      agent_read_accept_n,
  output logic      agent_write_accept_n,
  output logic      agent_bus_request_n,
  output logic      agent_drive_valid_n,
  output logic      null_return_command,
  output logic      resp_last,
  output logic      ext_done,
  output int        pend
);
  int wait_c;
  int up;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 0;
      wait_c <= 0;
      agent_read_accept_n <= 1'b1;
      agent_write_accept_n <= 1'b1;
      agent_bus_request_n <= 1'b1;
      agent_drive_valid_n <= 1'b1;
      null_return_command <= 1'b0;
      resp_last <= 1'b0;
      ext_done <= 1'b0;
    end else begin
      agent_read_accept_n <= rd_hold;
      agent_write_accept_n <= wr_hold;
      agent_bus_request_n <= ~ext_want;
      resp_last <= 1'b0;
      ext_done <= 1'b0;
      agent_drive_valid_n <= 1'b1;
      // The command lines float outside a request, so they never hold a value.
      null_return_command <= ~null_return_command;
      up = (cpu_addr_cycle && cpu_addr_is_read && !(split_mode && agent_read_accept_n)) ? 1 : 0;
      wait_c <= bus_master ? 0 : wait_c + 1;
      if (!bus_master && wait_c >= (slow ? 9 : 4)) begin
        wait_c <= 0;
        if (pend > 0) begin
          resp_last <= 1'b1;
          up = up - 1;
        end else if (ext_want) begin
          ext_done <= 1'b1;
        end else begin
          agent_drive_valid_n <= 1'b0;
          null_return_command <= 1'b1;
        end
      end
      pend <= pend + up;
    end
  end
endmodule // agent_model
`default_nettype wire

//--- test/testbench.sv
/* Self-checking bench of the flow-control block with an agent model.
   Assumes the design, its package and the agent model compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctrl_map.svh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ok, prev_rel;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, jv;
  logic        txq_valid, txq_read, txq_set_last, txq_take, resp_last, ext_done;
  logic        rr_n, wr_n, er_n, vi_n, nul, dv_n, ac, ac_rd, dc, rel_n, mp_n, bus_master;
  logic        rd_hold, wr_hold, ext_want, split_mode, slow, jitter, chk, last_rd;
  int          mismatches, checks_done, seed, cycles, hd, hd0, gap, min_gap, pend, i;
  logic        tq_rd[$], tq_last[$], exp_q[$];

  sysbus_request_flow_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .txq_valid(txq_valid), .txq_read(txq_read), .txq_set_last(txq_set_last),
    .txq_take(txq_take), .resp_last(resp_last), .ext_done(ext_done),
    .agent_read_accept_n(rr_n), .agent_write_accept_n(wr_n), .agent_bus_request_n(er_n),
    .agent_drive_valid_n(vi_n), .null_return_command(nul), .cpu_drive_valid_n(dv_n),
    .cpu_addr_cycle(ac), .cpu_addr_is_read(ac_rd), .cpu_data_cycle(dc),
    .bus_release_n(rel_n), .cpu_more_pending_n(mp_n), .bus_master(bus_master));
  agent_model agent (.pclk(pclk), .presetn(presetn), .rd_hold(rd_hold), .wr_hold(wr_hold),
    .ext_want(ext_want), .split_mode(split_mode), .slow(slow), .cpu_addr_cycle(ac),
    .cpu_addr_is_read(ac_rd), .bus_master(bus_master), .agent_read_accept_n(rr_n),
    .agent_write_accept_n(wr_n), .agent_bus_request_n(er_n), .agent_drive_valid_n(vi_n),
    .null_return_command(nul), .resp_last(resp_last), .ext_done(ext_done), .pend(pend));

  // ========================================================================
  // Clock, queue head driver and monitor
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (txq_take === 1'b1) hd = hd + 1;
    txq_valid <= hd < tq_rd.size();
    txq_read <= hd < tq_rd.size() ? tq_rd[hd] : 1'b0;
    txq_set_last <= hd < tq_rd.size() ? tq_last[hd] : 1'b0;
    if (jitter) begin
      jv = $random(seed);
      rd_hold <= jv[0];
      wr_hold <= jv[1];
    end
  end
  always @(posedge pclk) begin
    if (presetn) begin
      cycles = cycles + 1;
      gap = gap + 1;
      if (ac === 1'b1) begin
        check("addr_gap", gap >= min_gap, 1);
        if (ac_rd === 1'b1) check("reads_out", pend < 4, 1);
        gap = 0;
        last_rd = ac_rd;
        ok = ac_rd ? !rr_n : !wr_n;
      end
      if (txq_take === 1'b1 && exp_q.size() > 0) begin
        check("issue_kind", last_rd, exp_q.pop_front());
        if (chk) check("confirmed", ok, 1);
      end
      if (prev_rel === 1'b0) check("release_pulse", rel_n, 1);
      prev_rel = rel_n;
      if (cycles > 40000) begin
        mismatches++;
        stop_test();
      end
    end
  end

  // ========================================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic mode(input logic [2:0] m, input logic c, input int g);
    apb(1'b1, `FC_OFS_CTRL, {29'h0, m}, rv, e);
    chk <= c;
    min_gap <= g;
    split_mode <= m[1:0] == 2'h3;
  endtask
  task automatic push(input logic rd, input logic lst);
    @(negedge pclk);
    tq_rd.push_back(rd);
    tq_last.push_back(lst);
    exp_q.push_back(rd);
  endtask
  task automatic drain(input string nm);
    int k;
    for (k = 0; k < 4000; k++) begin
      @(negedge pclk);
      if (hd == tq_rd.size() && exp_q.size() == 0 && bus_master === 1'b1 && pend == 0) break;
    end
    check(nm, k < 4000, 1);
    $display("test %s done", nm);
  endtask
  task automatic stall(input logic rd);
    @(negedge pclk);
    rd_hold = rd;
    wr_hold = !rd;
    repeat (3) @(negedge pclk);
    hd0 = hd;
    push(rd, 1'b1);
    repeat (20) @(negedge pclk);
    check("stalled", hd, hd0);
    rd_hold = 1'b0;
    wr_hold = 1'b0;
    drain("stall");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    seed = 65;
    {mismatches, checks_done, cycles, hd, min_gap} = '0;
    gap = 100;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {txq_valid, txq_read, txq_set_last, rd_hold, wr_hold, ext_want} = '0;
    {split_mode, slow, jitter, chk, last_rd, ok} = '0;
    prev_rel = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FC_OFS_CTRL, 32'h0, rv, e);
    check("ctrl_reset", rv[2:0], 0);
    apb(1'b0, `FC_OFS_STATUS, 32'h0, rv, e);
    check("status_reset", rv[4:0], 0);
    apb(1'b1, 8'h0c, 32'h0, rv, e);
    check("unmapped", e, 1);
    for (i = 0; i < 8; i++) begin
      rv = $random(seed);
      apb(1'b1, `FC_OFS_CTRL, {rv[31:3], i[2:0]}, rv, e);
      apb(1'b0, `FC_OFS_CTRL, 32'h0, rv, e);
      check("ctrl_mode", rv[2:0], i[2:0]);
    end
    $display("test registers done");
    mode({1'b0, flow_ctrl_pkg::MODE_LEGACY}, 1'b0, 4);
    for (i = 0; i < 4; i++) push(i == 3, i == 2);
    drain("legacy_mix");
    stall(1'b1);
    stall(1'b0);
    mode({1'b1, flow_ctrl_pkg::MODE_PIPE}, 1'b0, 4);
    for (i = 0; i < 3; i++) push(1'b0, i == 2);
    drain("bus32_pipe");
    mode({1'b0, flow_ctrl_pkg::MODE_PIPE}, 1'b0, 2);
    for (i = 0; i < 4; i++) push(1'b0, i == 3);
    drain("pipelined");
    mode({1'b0, flow_ctrl_pkg::MODE_REISSUE}, 1'b1, 2);
    jitter = 1'b1;
    for (i = 0; i < 6; i++) push(1'b0, i == 5);
    repeat (40) @(negedge pclk);
    jitter = 1'b0;
    {rd_hold, wr_hold} = 2'b00;
    drain("reissue");
    mode({1'b0, flow_ctrl_pkg::MODE_MSR}, 1'b1, 2);
    slow = 1'b1;
    jitter = 1'b1;
    for (i = 0; i < 12; i++) begin
      rv = $random(seed);
      push(rv[0], rv[1]);
    end
    // A closing write ends the random write set, so later external requests meet a boundary.
    push(1'b0, 1'b1);
    repeat (150) @(negedge pclk);
    jitter = 1'b0;
    {rd_hold, wr_hold} = 2'b00;
    drain("split_reads");
    push(1'b1, 1'b0);
    for (i = 0; i < 30 && bus_master !== 1'b0; i++) @(negedge pclk);
    push(1'b1, 1'b0);
    repeat (3) @(negedge pclk);
    check("more_pending", mp_n, 0);
    drain("pending");
    ext_want = 1'b1;
    for (i = 0; i < 30 && bus_master !== 1'b0; i++) @(negedge pclk);
    check("ext_release", bus_master, 0);
    ext_want = 1'b0;
    drain("ext_request");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
